// ===== trd_pkg.sv
// Shared constants for the triangle raster and depth test engine
package trd_pkg;
   localparam int NREG = 33;
   localparam logic [5:0] R_CMD = 6'h00;
   localparam logic [5:0] R_LZ_DELTA = 6'h01;
   localparam logic [5:0] R_LZ_START = 6'h02;
   localparam logic [5:0] R_LGB_DELTA = 6'h03;
   localparam logic [5:0] R_LAR_DELTA = 6'h04;
   localparam logic [5:0] R_LGB_START = 6'h05;
   localparam logic [5:0] R_LAR_START = 6'h06;
   localparam logic [5:0] R_TX_START = 6'h07;
   localparam logic [5:0] R_TY_START = 6'h08;
   localparam logic [5:0] R_TZ_START = 6'h09;
   localparam logic [5:0] R_TGB_START = 6'h0a;
   localparam logic [5:0] R_TAR_START = 6'h0b;
   localparam logic [5:0] R_TMIP_START = 6'h0c;
   localparam logic [5:0] R_TU_START = 6'h0d;
   localparam logic [5:0] R_TV_START = 6'h0e;
   localparam logic [5:0] R_TW_START = 6'h0f;
   localparam logic [5:0] R_LONG_SLOPE = 6'h10;
   localparam logic [5:0] R_TZ_YDELTA = 6'h11;
   localparam logic [5:0] R_EDGE_COUNTS = 6'h12;
   localparam logic [5:0] R_LOW_XEND = 6'h13;
   localparam logic [5:0] R_LOW_SLOPE = 6'h14;
   localparam logic [5:0] R_UP_XEND = 6'h15;
   localparam logic [5:0] R_UP_SLOPE = 6'h16;
   localparam logic [5:0] R_TEX_UBASE = 6'h17;
   localparam logic [5:0] R_TEX_VBASE = 6'h18;
   localparam logic [5:0] R_DEPTH_BASE = 6'h19;
   localparam logic [5:0] R_COUNT_DIR = 6'h1a;
   localparam logic [5:0] R_FRAME_BASE = 6'h1b;
   localparam logic [5:0] R_STRIDE = 6'h1c;
   localparam logic [5:0] R_TZ_XDELTA = 6'h1d;
   localparam logic [5:0] R_TU_XDELTA = 6'h1e;
   localparam logic [5:0] R_TV_XDELTA = 6'h1f;
   localparam logic [5:0] R_STATUS = 6'h20;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam int CMD_OP_HI = 30;
   localparam int CMD_OP_LO = 27;
   localparam int CMD_ZMODE_HI = 25;
   localparam int CMD_ZMODE_LO = 24;
   localparam int CMD_ZWRITE = 23;
   localparam int CMD_ZFUNC_HI = 22;
   localparam int CMD_ZFUNC_LO = 20;
   localparam int DIR_BIT = 31;
   localparam logic [3:0] OP_TRI = 4'h4;
   localparam logic [3:0] OP_TRI_PERSP_A = 4'h5;
   localparam logic [3:0] OP_TRI_PERSP_B = 4'h6;
   localparam logic [3:0] OP_LINE = 4'h8;
   localparam logic [1:0] ZMODE_NORMAL = 2'h0;
   localparam logic [2:0] ZF_NEVER = 3'h0;
   localparam logic [2:0] ZF_GT = 3'h1;
   localparam logic [2:0] ZF_EQ = 3'h2;
   localparam logic [2:0] ZF_GE = 3'h3;
   localparam logic [2:0] ZF_LT = 3'h4;
   localparam logic [2:0] ZF_NE = 3'h5;
   localparam logic [2:0] ZF_LE = 3'h6;
   localparam logic [2:0] ZF_ALWAYS = 3'h7;
endpackage

// ===== trd_zcmp_if.sv
// Carrier between the scan engine and the depth comparator
`timescale 1ns/1ps
interface trd_zcmp_if;
   logic [2:0] func;
   logic [15:0] srcZ;
   logic [15:0] dstZ;
   logic pass;
   modport eng
   (
      output func,
      output srcZ,
      output dstZ,
      input pass
   );
   modport cmp
   (
      input func,
      input srcZ,
      input dstZ,
      output pass
   );
endinterface

// ===== trd_depth_cmp.sv
// Depth comparator: source depth against stored depth
`timescale 1ns/1ps
module trd_depth_cmp
   import trd_pkg::*;
(
   trd_zcmp_if.cmp zc
);
   always_comb
   begin
      unique case (zc.func)
         ZF_NEVER: zc.pass = 1'b0;
         ZF_GT: zc.pass = zc.srcZ > zc.dstZ;
         ZF_EQ: zc.pass = zc.srcZ == zc.dstZ;
         ZF_GE: zc.pass = zc.srcZ >= zc.dstZ;
         ZF_LT: zc.pass = zc.srcZ < zc.dstZ;
         ZF_NE: zc.pass = zc.srcZ != zc.dstZ;
         ZF_LE: zc.pass = zc.srcZ <= zc.dstZ;
         ZF_ALWAYS: zc.pass = 1'b1;
      endcase
   end
endmodule

// ===== trd_engine.sv
// Triangle and 3D line scan engine with depth test and AHB-Lite registers
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module trd_engine
   import trd_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic vmReq,
   output logic vmWe,
   output logic [31:0] vmAddr,
   output logic [31:0] vmWdata,
   output logic [1:0] vmSize,
   input wire logic [15:0] vmRdata,
   input wire logic vmAck,
   output logic [15:0] texU,
   output logic [15:0] texV,
   output logic [15:0] texW,
   output logic busy
);
   typedef enum logic [7:0]
   {
      ST_IDLE = 8'b0000_0001,
      ST_LINE = 8'b0000_0010,
      ST_PIX = 8'b0000_0100,
      ST_ZRD = 8'b0000_1000,
      ST_TEST = 8'b0001_0000,
      ST_CWR = 8'b0010_0000,
      ST_ZWR = 8'b0100_0000,
      ST_NEXT = 8'b1000_0000
   } trd_state_e;

   function automatic logic [15:0] addS16(input logic [15:0] a, input logic [15:0] b);
      addS16 = a + b;
   endfunction

   trd_zcmp_if zc();
   trd_depth_cmp uCmp
   (
      .zc(zc)
   );

   logic [31:0] regQ [NREG];
   logic [5:0] aIdxQ;
   logic aWrQ;
   logic aValidQ;
   logic launch;
   trd_state_e stateQ;
   logic [31:0] cmd;
   logic zOn;
   logic persp;
   logic isLine;
   logic dirLtr;
   logic [10:0] yQ;
   logic [31:0] xLongQ;
   logic [31:0] xOtherQ;
   logic [11:0] lineCntQ;
   logic [10:0] lowerLeftQ;
   logic [10:0] pixXQ;
   logic [11:0] pixLeftQ;
   logic [31:0] zRowQ;
   logic [31:0] zQ;
   logic [15:0] aQ;
   logic [15:0] rQ;
   logic [15:0] gQ;
   logic [15:0] bQ;
   logic [31:0] uQ;
   logic [31:0] vQ;
   logic [31:0] wQ;
   logic [15:0] dstZQ;
   logic [31:0] pixIdx;
   logic [10:0] spanA;
   logic [10:0] spanB;
   logic [11:0] spanW;
   logic [11:0] maxW;
   logic [15:0] pixCntQ;

   assign cmd = regQ[R_CMD];
   assign zOn = (cmd[CMD_ZMODE_HI:CMD_ZMODE_LO] == ZMODE_NORMAL)
      && (cmd[CMD_ZFUNC_HI:CMD_ZFUNC_LO] != ZF_NEVER);
   assign persp = (cmd[CMD_OP_HI:CMD_OP_LO] == OP_TRI_PERSP_A)
      || (cmd[CMD_OP_HI:CMD_OP_LO] == OP_TRI_PERSP_B);
   assign isLine = cmd[CMD_OP_HI:CMD_OP_LO] == OP_LINE;
   assign dirLtr = regQ[R_COUNT_DIR][DIR_BIT];
   assign busy = stateQ != ST_IDLE;

   // Zero wait state slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign launch = aValidQ && aWrQ && (aIdxQ == R_COUNT_DIR);

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aValidQ <= 1'b0;
         aWrQ <= 1'b0;
         aIdxQ <= 6'h00;
      end
      else if (hready)
      begin
         aValidQ <= hsel && htrans[1] && (haddr[1:0] == 2'h0) && (haddr[31:8] == 24'h00_0000);
         aWrQ <= hwrite;
         aIdxQ <= haddr[7:2];
      end
   end

   // Read data registered at the address phase so it stands in the data phase
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         hrdata <= REG_RST;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         if (haddr[7:2] == R_STATUS && haddr[31:8] == 24'h00_0000)
            hrdata <= {pixCntQ, 15'h0000, busy};
         else if (haddr[7:2] < R_STATUS && haddr[31:8] == 24'h00_0000)
            hrdata <= regQ[haddr[7:2]];
         else
            hrdata <= REG_RST;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++)
      begin : gReg
         always_ff @(posedge core_clk or negedge nrst)
         begin
            if (!nrst)
               regQ[gi] <= REG_RST;
            else if (aValidQ && aWrQ && aIdxQ == 6'(gi) && 6'(gi) != R_STATUS)
               regQ[gi] <= hwdata;
         end
      end
   endgenerate

   // Span set-up from the current edge positions, integer X in bits 30:20
   always_comb
   begin
      spanA = xLongQ[30:20];
      spanB = isLine ? xLongQ[30:20] : xOtherQ[30:20];
      spanW = dirLtr ? 12'(spanB - spanA) : 12'(spanA - spanB);
      if (spanW[11])
         spanW = 12'h000;
      maxW = 12'(regQ[R_LOW_XEND][30:20] - regQ[R_TX_START][30:20]);
      if (maxW[11])
         maxW = 12'(regQ[R_TX_START][30:20] - regQ[R_LOW_XEND][30:20]);
      if (!isLine && spanW > maxW)
         spanW = maxW;
   end

   assign pixIdx = 32'(yQ) * 32'(regQ[R_STRIDE][15:0]) + 32'(pixXQ);
   assign zc.func = cmd[CMD_ZFUNC_HI:CMD_ZFUNC_LO];
   assign zc.srcZ = zQ[31:16];
   assign zc.dstZ = dstZQ;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         stateQ <= ST_IDLE;
      else
      begin
         unique case (stateQ)
            ST_IDLE:
               if (launch)
                  stateQ <= ST_LINE;
            ST_LINE:
               stateQ <= (lineCntQ == 12'h000) ? ST_IDLE : ST_PIX;
            ST_PIX:
               stateQ <= zOn ? ST_ZRD : ST_CWR;
            ST_ZRD:
               if (vmAck)
                  stateQ <= ST_TEST;
            ST_TEST:
               stateQ <= zc.pass ? ST_CWR : ST_NEXT;
            ST_CWR:
               if (vmAck)
                  stateQ <= (zOn && cmd[CMD_ZWRITE]) ? ST_ZWR : ST_NEXT;
            ST_ZWR:
               if (vmAck)
                  stateQ <= ST_NEXT;
            ST_NEXT:
               if (pixLeftQ > 12'h001)
                  stateQ <= ST_PIX;
               else
                  stateQ <= (lineCntQ == 12'h001) ? ST_IDLE : ST_LINE;
         endcase
      end
   end

   // Scan line walk; Y falls each line so the shape is drawn bottom up
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         yQ <= 11'h000;
         xLongQ <= REG_RST;
         xOtherQ <= REG_RST;
         lineCntQ <= 12'h000;
         lowerLeftQ <= 11'h000;
      end
      else if (stateQ == ST_IDLE && launch)
      begin
         yQ <= regQ[R_TY_START][10:0];
         xLongQ <= regQ[R_TX_START];
         xOtherQ <= regQ[R_TX_START];
         lowerLeftQ <= regQ[R_EDGE_COUNTS][26:16];
         if (isLine)
            lineCntQ <= {1'b0, hwdata[10:0]};
         else
            lineCntQ <= 12'(regQ[R_EDGE_COUNTS][26:16]) + 12'(regQ[R_EDGE_COUNTS][10:0]);
      end
      else if (stateQ == ST_NEXT && pixLeftQ <= 12'h001)
      begin
         lineCntQ <= lineCntQ - 12'h001;
         yQ <= yQ - 11'h001;
         xLongQ <= xLongQ + regQ[R_LONG_SLOPE];
         if (lowerLeftQ > 11'h001)
         begin
            lowerLeftQ <= lowerLeftQ - 11'h001;
            xOtherQ <= xOtherQ + regQ[R_LOW_SLOPE];
         end
         else if (lowerLeftQ == 11'h001)
         begin
            // Switch to the upper edge at vertex 1
            lowerLeftQ <= 11'h000;
            xOtherQ <= regQ[R_UP_XEND];
         end
         else
            xOtherQ <= xOtherQ + regQ[R_UP_SLOPE];
      end
   end

   // Pixel walk along the span
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pixXQ <= 11'h000;
         pixLeftQ <= 12'h000;
      end
      else if (stateQ == ST_LINE)
      begin
         pixXQ <= spanA;
         pixLeftQ <= spanW + 12'h001;
      end
      else if (stateQ == ST_NEXT)
      begin
         pixLeftQ <= pixLeftQ - 12'h001;
         pixXQ <= dirLtr ? pixXQ + 11'h001 : pixXQ - 11'h001;
      end
   end

   // Depth interpolation, fractional 16.16
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         zRowQ <= REG_RST;
         zQ <= REG_RST;
      end
      else if (stateQ == ST_IDLE && launch)
         zRowQ <= isLine ? regQ[R_LZ_START] : regQ[R_TZ_START];
      else if (stateQ == ST_LINE)
         zQ <= zRowQ;
      else if (stateQ == ST_NEXT)
      begin
         if (pixLeftQ > 12'h001)
            zQ <= zQ + regQ[R_TZ_XDELTA];
         else
            zRowQ <= zRowQ + (isLine ? regQ[R_LZ_DELTA] : regQ[R_TZ_YDELTA]);
      end
   end

   // Colour channels; triangles keep their start colour across the shape
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aQ <= 16'h0000;
         rQ <= 16'h0000;
         gQ <= 16'h0000;
         bQ <= 16'h0000;
      end
      else if (stateQ == ST_IDLE && launch)
      begin
         {aQ, rQ} <= isLine ? regQ[R_LAR_START] : regQ[R_TAR_START];
         {gQ, bQ} <= isLine ? regQ[R_LGB_START] : regQ[R_TGB_START];
      end
      else if (stateQ == ST_NEXT && pixLeftQ <= 12'h001 && isLine)
      begin
         aQ <= addS16(aQ, regQ[R_LAR_DELTA][31:16]);
         rQ <= addS16(rQ, regQ[R_LAR_DELTA][15:0]);
         gQ <= addS16(gQ, regQ[R_LGB_DELTA][31:16]);
         bQ <= addS16(bQ, regQ[R_LGB_DELTA][15:0]);
      end
   end

   // Texture coordinates; only stepped across spans
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         uQ <= REG_RST;
         vQ <= REG_RST;
         wQ <= REG_RST;
      end
      else if (stateQ == ST_IDLE && launch)
      begin
         uQ <= regQ[R_TU_START];
         vQ <= regQ[R_TV_START];
         wQ <= persp ? regQ[R_TW_START] : REG_RST;
      end
      else if (stateQ == ST_NEXT && pixLeftQ > 12'h001)
      begin
         uQ <= uQ + regQ[R_TU_XDELTA];
         vQ <= vQ + regQ[R_TV_XDELTA];
      end
   end

   // Perspective coordinates carry four more fraction bits
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         texU <= 16'h0000;
         texV <= 16'h0000;
         texW <= 16'h0000;
      end
      else if (stateQ == ST_PIX && !isLine)
      begin
         texU <= addS16(persp ? uQ[27:12] : uQ[31:16], regQ[R_TEX_UBASE][15:0]);
         texV <= addS16(persp ? vQ[27:12] : vQ[31:16], regQ[R_TEX_VBASE][15:0]);
         texW <= wQ[31:16];
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         dstZQ <= 16'h0000;
      else if (stateQ == ST_ZRD && vmAck)
         dstZQ <= vmRdata;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         pixCntQ <= 16'h0000;
      else if (stateQ == ST_IDLE && launch)
         pixCntQ <= 16'h0000;
      else if (stateQ == ST_CWR && vmAck)
         pixCntQ <= pixCntQ + 16'h0001;
   end

   // Memory request; address and data are loaded one cycle before each access
   assign vmReq = (stateQ == ST_ZRD) || (stateQ == ST_CWR) || (stateQ == ST_ZWR);

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         vmWe <= 1'b0;
         vmAddr <= REG_RST;
         vmWdata <= REG_RST;
         vmSize <= 2'h0;
      end
      else if (stateQ == ST_PIX && zOn)
      begin
         vmWe <= 1'b0;
         vmAddr <= regQ[R_DEPTH_BASE] + {pixIdx[30:0], 1'b0};
         vmSize <= 2'h1;
      end
      else if ((stateQ == ST_PIX && !zOn) || (stateQ == ST_TEST && zc.pass))
      begin
         vmWe <= 1'b1;
         vmAddr <= regQ[R_FRAME_BASE] + {pixIdx[29:0], 2'h0};
         vmWdata <= {aQ[15:8], rQ[15:8], gQ[15:8], bQ[15:8]};
         vmSize <= 2'h2;
      end
      else if (stateQ == ST_CWR && vmAck && zOn && cmd[CMD_ZWRITE])
      begin
         vmWe <= 1'b1;
         vmAddr <= regQ[R_DEPTH_BASE] + {pixIdx[30:0], 1'b0};
         vmWdata <= {16'h0000, zQ[31:16]};
         vmSize <= 2'h1;
      end
   end
endmodule

// ===== trd_engine_sva.sv
// Port checker for the raster engine
`timescale 1ns/1ps
module trd_engine_chk
   import trd_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic vmReq,
   input wire logic vmWe,
   input wire logic [31:0] vmAddr,
   input wire logic [31:0] vmWdata,
   input wire logic [1:0] vmSize,
   input wire logic vmAck,
   input wire logic busy
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_zero_wait: assert property (hreadyout == 1'b1)
      else $error("bus wait state seen");
   a_req_hold: assert property (vmReq && !vmAck |=> vmReq && $stable(vmAddr) && $stable(vmWe)
      && $stable(vmSize) && $stable(vmWdata))
      else $error("memory request changed before ack");
   a_gap_after: assert property (vmReq && vmAck |=> !vmReq
      || (vmWe && vmSize == 2'h1 && $past(vmSize) == 2'h2))
      else $error("no idle cycle after ack");
   a_size_legal: assert property (vmReq |-> vmSize == 2'h1 || vmSize == 2'h2)
      else $error("illegal access size");
   a_colour_wr: assert property (vmReq && vmSize == 2'h2 |-> vmWe && vmAddr[1:0] == 2'h0)
      else $error("colour access not an aligned write");
   a_depth_align: assert property (vmReq && vmSize == 2'h1 |-> vmAddr[0] == 1'b0)
      else $error("depth word misaligned");
   a_idle_quiet: assert property (!busy |-> !vmReq)
      else $error("memory request while idle");
   a_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:2] > 6'h20
      |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule

bind trd_engine trd_engine_chk u_chk
(
   .core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .vmReq, .vmWe, .vmAddr, .vmWdata, .vmSize, .vmAck, .busy
);

// ===== trd_vmem_model.sv
// Video memory model: answers requests, checks pairing and scan order
`timescale 1ns/1ps
module trd_vmem_model
#(
   parameter logic [15:0] SRCZ = 16'h0,
   parameter logic [31:0] ZBASE = 32'h0,
   parameter logic [31:0] FBASE = 32'h0
)
(
   input wire logic core_clk,
   input wire logic vmReq,
   input wire logic vmWe,
   input wire logic [31:0] vmAddr,
   input wire logic [31:0] vmWdata,
   input wire logic [1:0] vmSize,
   output logic [15:0] vmRdata,
   output logic vmAck,
   input wire logic clr,
   input wire logic [15:0] storedZ,
   input wire logic ltr,
   input wire logic testOn,
   input wire logic [1:0] dly,
   output int nRd,
   output int nCw,
   output int nZw,
   output int nRows,
   output int nErr
);
   logic [1:0] waitCnt = 2'h0;
   logic [31:0] zIdx = 32'h0;
   logic [31:0] prevC = 32'h0;
   int d;
   initial nErr = 0;
   // Slow answers stretch the request
   assign vmAck = vmReq && (waitCnt >= dly);
   // Unanswered data line shows the inverse, never a stale match
   assign vmRdata = (vmAck && !vmWe) ? storedZ : ~storedZ;
   always @(posedge core_clk)
   begin
      waitCnt <= (vmReq && !vmAck) ? waitCnt + 2'h1 : 2'h0;
      if (clr)
      begin
         nRd = 0;
         nCw = 0;
         nZw = 0;
         nRows = 0;
      end
      else if (vmReq && vmAck)
      begin
         if (vmSize == 2'h1 && !vmWe)
         begin
            nRd++;
            zIdx = vmAddr - ZBASE;
            if (zIdx[0]) nErr++;
         end
         else if (vmSize == 2'h1)
         begin
            nZw++;
            if (vmWdata[15:0] !== SRCZ || vmAddr - ZBASE !== zIdx) nErr++;
         end
         else
         begin
            nCw++;
            if (testOn && vmAddr - FBASE !== {zIdx[30:0], 1'b0}) nErr++;
            d = vmAddr - prevC;
            if (nCw == 1) nRows = 1;
            else if (d == 4 || d == -4) nErr += ((d > 0) != ltr);
            else nRows++;
            if (nCw > 1 && d != 4 && d != -4 && d > 0) nErr++;
            prevC = vmAddr;
         end
      end
   end
endmodule

// ===== tb_triangle_raster_depth_test.sv
// Testbench for the raster and depth test engine
`timescale 1ns/1ps
module tb_triangle_raster_depth_test;
   import trd_pkg::*;
   localparam logic [15:0] SRCZ = 16'h4000;
   localparam logic [31:0] ZBASE = 32'h0001_0000;
   localparam logic [31:0] FBASE = 32'h0004_0000;
   localparam logic [5:0] PI [20] = '{R_TX_START, R_TY_START, R_TZ_START, R_TZ_XDELTA, R_TZ_YDELTA,
      R_LONG_SLOPE, R_EDGE_COUNTS, R_LOW_SLOPE, R_UP_SLOPE, R_DEPTH_BASE, R_FRAME_BASE, R_STRIDE, R_TEX_UBASE,
      R_TU_START, R_TW_START, R_TEX_VBASE, R_LAR_START, R_LGB_START, R_LAR_DELTA, R_LGB_DELTA};
   localparam logic [31:0] PV [20] = '{32'h00a0_0000, 32'h0000_0014, {SRCZ, 16'h0}, 32'h0, 32'h0,
      32'h0, 32'h0001_0001, 32'h0, 32'h0, ZBASE, FBASE, 32'h0000_0040, 32'h0000_0123,
      32'h0012_3456, 32'h0abc_0000, 32'h0000_0456, 32'h1000_2000, 32'h3000_4000, 32'h0100_0200, 32'h0300_0400};
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, vmAddr, vmWdata, rd;
   logic hreadyout, hresp, vmReq, vmWe, vmAck, busy;
   logic [1:0] vmSize;
   logic [15:0] vmRdata;
   logic [15:0] texU, texV, texW;
   logic [31:0] lastCw = 32'h0;
   logic [15:0] storedZ = 16'h0;
   logic ltr = 1'b0;
   logic testOn = 1'b0;
   logic clr = 1'b0;
   logic [1:0] dly = 2'h0;
   int nRd, nCw, nZw, nRows, nErr;
   int num_errors = 0;
   int n_compared = 0;
   always #2 core_clk = ~core_clk;
   trd_engine DUT
   (
      .core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .vmReq, .vmWe, .vmAddr, .vmWdata, .vmSize, .vmRdata, .vmAck,
      .texU, .texV, .texW, .busy
   );
   trd_vmem_model #(.SRCZ(SRCZ), .ZBASE(ZBASE), .FBASE(FBASE)) u_mem
   (
      .core_clk, .vmReq, .vmWe, .vmAddr, .vmWdata, .vmSize, .vmRdata, .vmAck, .clr, .storedZ,
      .ltr, .testOn, .dly, .nRd, .nCw, .nZw, .nRows, .nErr
   );
   // Last colour word accepted by memory, for the line colour steps
   always @(posedge core_clk)
      if (vmReq && vmAck && vmWe && vmSize == 2'h2)
         lastCw <= vmWdata;
   task automatic results();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1)
      begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic wait_edge(input logic ready, input int lim);
      int k;
      k = 0;
      @(posedge core_clk);
      while (((ready && hreadyout !== 1'b1) || (!ready && busy !== 1'b0)) && k < lim)
      begin
         k++;
         @(posedge core_clk);
      end
      if (k == lim)
      begin
         check(1'b0, "wait limit reached");
         results();
      end
   endtask
   // One single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, idx, 2'h0};
      wait_edge(1'b1, 100);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_edge(1'b1, 100);
      rd = hrdata;
   endtask
   function automatic logic zpass(input logic [2:0] f, input logic [15:0] s, input logic [15:0] z);
      case (f)
         ZF_GT: return s > z;
         ZF_EQ: return s == z;
         ZF_GE: return s >= z;
         ZF_LT: return s < z;
         ZF_NE: return s != z;
         ZF_LE: return s <= z;
         ZF_ALWAYS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   task automatic draw(input logic [3:0] op, input logic [1:0] mode, input logic [2:0] f, input logic [15:0] sz);
      logic act, ok;
      act = (mode == ZMODE_NORMAL) && (f != ZF_NEVER);
      ok = zpass(f, SRCZ, sz);
      storedZ <= sz;
      ltr <= f[1];
      dly <= {f[2], f[0]};
      testOn <= act;
      clr <= 1'b1;
      // Far edges on the side the direction bit implies; upper one lies past the clamp
      ahb(1'b1, R_LOW_XEND, f[1] ? 32'h00d0_0000 : 32'h0070_0000);
      clr <= 1'b0;
      ahb(1'b1, R_UP_XEND, f[1] ? 32'h00f0_0000 : 32'h0050_0000);
      ahb(1'b1, R_CMD, {1'b0, op, 1'b0, mode, f[0], f, 20'h0});
      // Count of two lines; triangles take theirs from the edge counts
      ahb(1'b1, R_COUNT_DIR, {f[1], 20'h0, 11'h002});
      repeat (2) @(posedge core_clk);
      wait_edge(1'b0, 5000);
      check(nErr == 0, "memory link order or address");
      if (act)
      begin
         check(nRd > 0, "no depth reads");
         check(nCw == (ok ? nRd : 0), "colour writes against compare");
         check(nZw == (ok && f[0] ? nRd : 0), "depth writes");
      end
      else
      begin
         check(nRd == 0 && nZw == 0, "depth buffer touched");
         check(nCw > 0, "no pixels written");
      end
      if (nCw > 0)
      begin
         check(nRows == 2, "scan line count");
         check(nCw == (op == OP_LINE ? 2 : 5), "pixels per shape");
      end
      if (op == OP_LINE)
         check(lastCw === 32'h1122_3344, "line colour step");
      else if (op == OP_TRI_PERSP_A || op == OP_TRI_PERSP_B)
         check(texU === 16'h0246 && texW === 16'h0abc, "perspective texture");
      else
         check(texU === 16'h0135 && texW === 16'h0000, "plain texture");
      if (op != OP_LINE)
         check(texV === 16'h0456, "texture base");
   endtask
   initial
   begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      ahb(1'b0, R_TZ_START, 32'h0);
      check(rd === REG_RST, "reset value");
      ahb(1'b1, R_STATUS, 32'hffff_ffff);
      ahb(1'b0, R_STATUS, 32'h0);
      check(rd === 32'h0, "status written");
      ahb(1'b1, 6'h21, 32'hffff_ffff);
      ahb(1'b0, 6'h21, 32'h0);
      check(rd === 32'h0, "unmapped read");
      // Edge counts: lower then upper edge, bottom vertex first
      for (int i = 0; i < 20; i++)
      begin
         ahb(1'b1, PI[i], PV[i]);
         ahb(1'b0, PI[i], 32'h0);
         check(rd === PV[i], "register readback");
      end
      for (int f = 0; f < 8; f++)
         for (int s = 0; s < 3; s++)
            draw(OP_TRI, ZMODE_NORMAL, 3'(f), SRCZ - 16'h1 + 16'(s));
      draw(OP_TRI_PERSP_A, ZMODE_NORMAL, ZF_LE, SRCZ);
      draw(OP_TRI_PERSP_B, ZMODE_NORMAL, ZF_GT, SRCZ);
      draw(OP_TRI, 2'h1, ZF_ALWAYS, SRCZ);
      draw(OP_TRI, 2'h2, ZF_EQ, SRCZ);
      draw(OP_LINE, ZMODE_NORMAL, ZF_NEVER, SRCZ);
      results();
   end
endmodule
